// ### common/pgiu_pkg.sv
package pgiu_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NPAD       = 123;
  localparam int NPAD_V     = 128;
  localparam int NIRQ       = 16;
  localparam int NPSMI      = 32;
  localparam int NRG        = 16;
  localparam int PCR_W      = 4;
  localparam int RED_LAST   = 78;
  localparam int RED_WORDS  = RED_LAST / 2 + 1;

  // ----------------------------------------------------------------
  // Byte offsets
  // ----------------------------------------------------------------
  localparam logic [13:0] OFS_ID_LO  = 14'h0004;
  localparam logic [13:0] OFS_ID_HI  = 14'h0008;
  localparam logic [13:0] OFS_FLAG   = 14'h0014;
  localparam logic [13:0] OFS_REQEN  = 14'h0018;
  localparam logic [13:0] OFS_RISE   = 14'h0028;
  localparam logic [13:0] OFS_FALL   = 14'h002c;
  localparam logic [13:0] OFS_FILT   = 14'h0030;
  localparam logic [13:0] OFS_PCR    = 14'h0040;
  localparam logic [13:0] OFS_PSMI   = 14'h0500;
  localparam logic [13:0] OFS_GPDO   = 14'h0600;
  localparam logic [13:0] OFS_GPDI   = 14'h0800;
  localparam logic [13:0] OFS_PGPDO  = 14'h0c00;
  localparam logic [13:0] OFS_PGPDI  = 14'h0c40;
  localparam logic [13:0] OFS_MASKED_PORT_OUTPUT = 14'h0c80;
  localparam logic [13:0] OFS_IFMC   = 14'h1000;
  localparam logic [13:0] OFS_FILTER_CLOCK_PRESCALE  = 14'h1080;

  // Region indices, in the order of the tables below
  localparam int RG_ID_LO = 0;
  localparam int RG_ID_HI = 1;
  localparam int RG_FLAG  = 2;
  localparam int RG_REQEN = 3;
  localparam int RG_RISE  = 4;
  localparam int RG_FALL  = 5;
  localparam int RG_FILT  = 6;
  localparam int RG_PCR   = 7;
  localparam int RG_PSMI  = 8;
  localparam int RG_GPDO  = 9;
  localparam int RG_GPDI  = 10;
  localparam int RG_PGPDO = 11;
  localparam int RG_PGPDI = 12;
  localparam int RG_MASKED_PORT_OUTPUT = 13;
  localparam int RG_IFMC  = 14;
  localparam int RG_FILTER_CLOCK_PRESCALE = 15;
  localparam int RG_NONE  = 16;

  localparam logic [13:0] RG_BASE [NRG] = '{OFS_ID_LO, OFS_ID_HI, OFS_FLAG, OFS_REQEN,
    OFS_RISE, OFS_FALL, OFS_FILT, OFS_PCR, OFS_PSMI, OFS_GPDO, OFS_GPDI, OFS_PGPDO,
    OFS_PGPDI, OFS_MASKED_PORT_OUTPUT, OFS_IFMC, OFS_FILTER_CLOCK_PRESCALE};
  localparam logic [11:0] RG_WORDS [NRG] = '{12'h001, 12'h001, 12'h001, 12'h001,
    12'h001, 12'h001, 12'h001, 12'h03e, 12'h008, 12'h01f, 12'h01f, 12'h004,
    12'h004, 12'h008, 12'h010, 12'h001};

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] IDENT_LO_VAL = 32'h0000_1a2b;  // Arbitrary value
  localparam logic [31:0] IDENT_HI_VAL = 32'h0000_3c4d;  // Arbitrary value
  localparam logic [PCR_W-1:0] PCR_RST = 4'h0;
  localparam logic [3:0]  IFMC_RST  = 4'h0;
  localparam logic [3:0]  FILTER_CLOCK_PRESCALE_RST = 4'h0;
  localparam logic [15:0] EN16_RST  = 16'h0000;

  // Pad configuration: select 0 is GPIO, 1..3 alternate functions
  typedef struct packed {
    logic [1:0] sel;
    logic       ibe;
    logic       obe;
  } pgiu_pcr_s;

endpackage : pgiu_pkg

// ### src/pgiu_glitch_filter.sv
module pgiu_glitch_filter (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       ce,
  // Control
  input  wire logic       tick,
  input  wire logic       filt_en,
  input  wire logic [3:0] max_cnt,
  // Data
  input  wire logic       din,
  output logic            dout
);

  logic [3:0] cnt_q;
  logic       dout_q;

  assign dout = dout_q;

  // Level must hold for max_cnt+1 prescaled ticks before it is passed on
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= 4'h0;
      dout_q <= 1'b0;
    end else if (ce) begin
      if (!filt_en || din == dout_q) begin
        cnt_q  <= 4'h0;
        dout_q <= din;
      end else if (tick) begin
        if (cnt_q >= max_cnt) begin
          cnt_q  <= 4'h0;
          dout_q <= din;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end

endmodule : pgiu_glitch_filter

// ### src/pgiu_top.sv
// The APB register port was decided locally.
module pgiu_top (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire logic                  ce,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [13:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Pads and alternate functions
  input  wire logic [122:0]          pad_in,
  output logic      [122:0]          pad_out,
  output logic      [122:0]          pad_oe_n,
  output logic      [122:0]          pad_ibe,
  input  wire logic [3:1][122:0]     alt_out,
  input  wire logic [3:1][122:0]     alt_oe,
  output logic      [31:0][3:0]      input_src_sel,
  // Reduced-pin variant select and external interrupts
  input  wire logic                  reduced_pins,
  input  wire logic [15:0]           external_irq_pin,
  output logic      [1:0]            irq_vec,
  output logic                       irq
);

  // ----------------------------------------------------------------
  // APB decode and handshake
  // ----------------------------------------------------------------
  logic [11:0] aw, off;
  int          rg;
  logic        err_d, err_q, cap_q, cap_fire, wr_fire;
  logic [31:0] rd_d, prdata_q;

  assign aw = paddr[13:2];

  // Word address to region and word index within it
  always_comb begin
    rg  = pgiu_pkg::RG_NONE;
    off = 12'h000;
    for (int r = 0; r < pgiu_pkg::NRG; r++) begin
      if (aw >= pgiu_pkg::RG_BASE[r][13:2] &&
          aw < pgiu_pkg::RG_BASE[r][13:2] + pgiu_pkg::RG_WORDS[r]) begin
        rg  = r;
        off = aw - pgiu_pkg::RG_BASE[r][13:2];
      end
    end
    err_d = (rg == pgiu_pkg::RG_NONE);
    if (reduced_pins && rg == pgiu_pkg::RG_PCR && off >= 12'(pgiu_pkg::RED_WORDS)) begin
      err_d = 1'b1;
    end
  end

  // Capture happens once per transfer, so ce low in setup only adds a wait
  assign cap_fire = psel & ce & ~cap_q;
  assign pready   = psel & penable & ce & cap_q;
  assign pslverr  = pready & err_q;
  assign prdata   = prdata_q;
  assign wr_fire  = pready & pwrite & ~err_q;

  // Transfer capture: read data and error are registered
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cap_q    <= 1'b0;
      err_q    <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (cap_fire) begin
      cap_q    <= 1'b1;
      err_q    <= err_d;
      prdata_q <= err_d ? 32'h0000_0000 : rd_d;
    end else if (pready) begin
      cap_q <= 1'b0;
    end
  end

  // Byte-lane merge for the 16-bit control registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
    logic [15:0] res;
    res = old;
    if (st[0]) res[7:0] = wd[7:0];
    if (st[1]) res[15:8] = wd[15:8];
    return res;
  endfunction : merge16

  // ----------------------------------------------------------------
  // Pads
  // ----------------------------------------------------------------
  logic [pgiu_pkg::NPAD_V-1:0]            gpdo_v;
  logic [pgiu_pkg::NPAD_V-1:0]            gpdi_v;
  logic [pgiu_pkg::NPAD_V-1:0][3:0]       pcr_v;

  genvar i;
  generate
    for (i = 0; i < pgiu_pkg::NPAD; i++) begin : g_pad
      logic               do_q;
      pgiu_pkg::pgiu_pcr_s pcr_q;

      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          do_q <= 1'b0;
        end else if (wr_fire) begin
          if (rg == pgiu_pkg::RG_GPDO && off == 12'(i / 4) && pstrb[i % 4]) begin
            do_q <= pwdata[8 * (i % 4)];
          end
          if (rg == pgiu_pkg::RG_PGPDO && off == 12'(i / 32) && pstrb[(i % 32) / 8]) begin
            do_q <= pwdata[i % 32];
          end
          if (rg == pgiu_pkg::RG_MASKED_PORT_OUTPUT && off == 12'(i / 16) && pwdata[16 + i % 16]) begin
            do_q <= pwdata[i % 16];
          end
        end
      end

      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          pcr_q <= pgiu_pkg::PCR_RST;
        end else if (wr_fire && rg == pgiu_pkg::RG_PCR && off == 12'(i / 2) &&
                     pstrb[2 * (i % 2)] && !(reduced_pins && i > pgiu_pkg::RED_LAST)) begin
          pcr_q <= pgiu_pkg::pgiu_pcr_s'(pwdata[16 * (i % 2) +: pgiu_pkg::PCR_W]);
        end
      end

      assign pad_out[i]  = (pcr_q.sel == 2'h0) ? do_q : alt_out[pcr_q.sel][i];
      assign pad_oe_n[i] = (pcr_q.sel == 2'h0) ? ~pcr_q.obe : ~alt_oe[pcr_q.sel][i];
      assign pad_ibe[i]  = pcr_q.ibe;
      assign gpdi_v[i]   = pad_in[i] & pcr_q.ibe;
      assign gpdo_v[i]   = do_q;
      assign pcr_v[i]    = pcr_q;
    end
    for (i = pgiu_pkg::NPAD; i < pgiu_pkg::NPAD_V; i++) begin : g_nopad
      assign gpdi_v[i] = 1'b0;
      assign gpdo_v[i] = 1'b0;
      assign pcr_v[i]  = 4'h0;
    end
  endgenerate

  // Input source selects, one byte lane each
  generate
    for (i = 0; i < pgiu_pkg::NPSMI; i++) begin : g_psmi
      logic [3:0] sel_q;
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          sel_q <= 4'h0;
        end else if (wr_fire && rg == pgiu_pkg::RG_PSMI && off == 12'(i / 4) &&
                     pstrb[i % 4]) begin
          sel_q <= pwdata[8 * (i % 4) +: 4];
        end
      end
      assign input_src_sel[i] = sel_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // External interrupts
  // ----------------------------------------------------------------
  logic [15:0]      flag_q, req_en_q, rise_en_q, fall_en_q, filt_en_q;
  logic [3:0]       filter_clock_prescale_q, pre_q;
  logic             tick;
  logic [15:0]      rise_ev, fall_ev, ev, clr;
  logic [15:0][3:0] ifmc_v;

  // Filter prescaler shared by all sixteen channels
  assign tick = (pre_q == filter_clock_prescale_q);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= 4'h0;
    end else if (ce) begin
      pre_q <= tick ? 4'h0 : pre_q + 4'h1;
    end
  end

  generate
    for (i = 0; i < pgiu_pkg::NIRQ; i++) begin : g_irq
      logic       s1_q, s2_q, prev_q, filt;
      logic [3:0] ifmc_q;

      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          s1_q   <= 1'b0;
          s2_q   <= 1'b0;
          prev_q <= 1'b0;
        end else if (ce) begin
          s1_q   <= external_irq_pin[i];
          s2_q   <= s1_q;
          prev_q <= filt;
        end
      end

      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          ifmc_q <= pgiu_pkg::IFMC_RST;
        end else if (wr_fire && rg == pgiu_pkg::RG_IFMC && off == 12'(i) && pstrb[0]) begin
          ifmc_q <= pwdata[3:0];
        end
      end

      pgiu_glitch_filter u_filt (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .ce      (ce),
        .tick    (tick),
        .filt_en (filt_en_q[i]),
        .max_cnt (ifmc_q),
        .din     (s2_q),
        .dout    (filt)
      );

      assign rise_ev[i] = filt & ~prev_q & rise_en_q[i];
      assign fall_ev[i] = ~filt & prev_q & fall_en_q[i];
      assign ifmc_v[i]  = ifmc_q;
    end
  endgenerate

  assign ev  = rise_ev | fall_ev;
  assign clr = (wr_fire && rg == pgiu_pkg::RG_FLAG) ?
               (pwdata[15:0] & {{8{pstrb[1]}}, {8{pstrb[0]}}}) : 16'h0000;

  // sticky flags, a new edge beats a clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flag_q <= 16'h0000;
    end else if (ce) begin
      flag_q <= (flag_q & ~clr) | ev;
    end
  end

  // Interrupt control registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      req_en_q  <= pgiu_pkg::EN16_RST;
      rise_en_q <= pgiu_pkg::EN16_RST;
      fall_en_q <= pgiu_pkg::EN16_RST;
      filt_en_q <= pgiu_pkg::EN16_RST;
      filter_clock_prescale_q   <= pgiu_pkg::FILTER_CLOCK_PRESCALE_RST;
    end else if (wr_fire) begin
      if (rg == pgiu_pkg::RG_REQEN) req_en_q <= merge16(req_en_q, pwdata, pstrb);
      if (rg == pgiu_pkg::RG_RISE) rise_en_q <= merge16(rise_en_q, pwdata, pstrb);
      if (rg == pgiu_pkg::RG_FALL) fall_en_q <= merge16(fall_en_q, pwdata, pstrb);
      if (rg == pgiu_pkg::RG_FILT) filt_en_q <= merge16(filt_en_q, pwdata, pstrb);
      if (rg == pgiu_pkg::RG_FILTER_CLOCK_PRESCALE && pstrb[0]) filter_clock_prescale_q <= pwdata[3:0];
    end
  end

  assign irq_vec[0] = |(flag_q[7:0] & req_en_q[7:0]);
  assign irq_vec[1] = |(flag_q[15:8] & req_en_q[15:8]);
  assign irq        = |irq_vec;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // per-region read data words
  always_comb begin
    int p;
    p    = 0;
    rd_d = 32'h0000_0000;
    case (rg)
      pgiu_pkg::RG_ID_LO: rd_d = pgiu_pkg::IDENT_LO_VAL;
      pgiu_pkg::RG_ID_HI: rd_d = pgiu_pkg::IDENT_HI_VAL;
      pgiu_pkg::RG_FLAG:  rd_d = {16'h0000, flag_q};
      pgiu_pkg::RG_REQEN: rd_d = {16'h0000, req_en_q};
      pgiu_pkg::RG_RISE:  rd_d = {16'h0000, rise_en_q};
      pgiu_pkg::RG_FALL:  rd_d = {16'h0000, fall_en_q};
      pgiu_pkg::RG_FILT:  rd_d = {16'h0000, filt_en_q};
      pgiu_pkg::RG_PCR: begin
        for (int h = 0; h < 2; h++) begin
          p = 2 * int'(off) + h;
          rd_d[16 * h +: pgiu_pkg::PCR_W] = pcr_v[p[6:0]];
        end
      end
      pgiu_pkg::RG_PSMI: begin
        for (int j = 0; j < 4; j++) begin
          p = 4 * int'(off) + j;
          rd_d[8 * j +: 4] = input_src_sel[p[4:0]];
        end
      end
      pgiu_pkg::RG_GPDO, pgiu_pkg::RG_GPDI: begin
        for (int j = 0; j < 4; j++) begin
          p = 4 * int'(off) + j;
          rd_d[8 * j] = (rg == pgiu_pkg::RG_GPDO) ? gpdo_v[p[6:0]] : gpdi_v[p[6:0]];
        end
      end
      pgiu_pkg::RG_PGPDO: rd_d = gpdo_v[32 * off[1:0] +: 32];
      pgiu_pkg::RG_PGPDI: rd_d = gpdi_v[32 * off[1:0] +: 32];
      pgiu_pkg::RG_IFMC:  rd_d = {28'h0000000, ifmc_v[off[3:0]]};
      pgiu_pkg::RG_FILTER_CLOCK_PRESCALE: rd_d = {28'h0000000, filter_clock_prescale_q};
      default:            rd_d = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_flag_set_edge: assert property (ce && ev != 16'h0 |=> (flag_q & $past(ev)) == $past(ev))
    else $error("enabled edge did not set its flag");
  a_flag_hold_zero: assert property (ce && ev == 16'h0 && clr == 16'h0 |=> $stable(flag_q))
    else $error("flag changed without edge or clear");
  a_edge_enable: assert property ((rise_ev & ~rise_en_q) == 16'h0 &&
                                  (fall_ev & ~fall_en_q) == 16'h0)
    else $error("edge detected on disabled pin");
  a_irq_gated: assert property ((flag_q & req_en_q) == 16'h0 |-> !irq)
    else $error("interrupt without enabled flag");
  a_rise_once: assert property (ce && rise_ev[3] |=> !rise_ev[3])
    else $error("edge counted twice");
  a_pad_drive: assert property (pcr_v[0] == 4'h1 |-> pad_out[0] == gpdo_v[0] && !pad_oe_n[0])
    else $error("output pad not driving data");
  a_gpdi_read: assert property (cap_fire && rg == pgiu_pkg::RG_GPDI && off == 12'h0
                                |=> prdata_q[0] == $past(pad_in[0] & pcr_v[0][1]))
    else $error("input readback wrong");
  a_port_read: assert property (cap_fire && rg == pgiu_pkg::RG_PGPDI && off == 12'h0
                                |=> prdata_q[15:0] == $past(gpdi_v[15:0]))
    else $error("port readback wrong");
  a_reserved_err: assert property (cap_fire && paddr == 14'h0000 |=> err_q)
    else $error("reserved access not errored");
  a_reduced_pcr: assert property (cap_fire && reduced_pins && paddr == 14'h00e0 |=> err_q)
    else $error("reduced pad config not reserved");
  a_masked_keep: assert property (wr_fire && rg == pgiu_pkg::RG_MASKED_PORT_OUTPUT && off == 12'h0 &&
                                  !pwdata[16] |=> $stable(gpdo_v[0]))
    else $error("masked bit changed");

  c_flag_set:  cover property ($rose(flag_q[3]));
  c_irq_rise:  cover property ($rose(irq));
  c_error:     cover property (pready && pslverr);
  c_masked_wr: cover property (wr_fire && rg == pgiu_pkg::RG_MASKED_PORT_OUTPUT);

endmodule : pgiu_top

// ### dv/pgiu_pad_model.sv
module pgiu_pad_model (
  // Design side
  input  wire logic [122:0] pad_out,
  input  wire logic [122:0] pad_oe_n,
  // Bench control
  input  wire logic [122:0] pad_ext,
  input  wire logic [15:0]  irq_lvl,
  // Toward the design
  output logic      [122:0] pad_in,
  output logic      [15:0]  external_irq_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // A driven pad shows its own drive; an undriven one shows the outside level
  assign pad_in = (pad_out & ~pad_oe_n) | (pad_ext & pad_oe_n);

  // Interrupt pins come from outside devices, asynchronous to the unit clock
  assign external_irq_pin = irq_lvl;
endmodule : pgiu_pad_model

// ### dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              clk_sys, arst_n, psel, penable, pwrite, pready, pslverr;
  logic              reduced_pins, irq, e, ce;
  logic [13:0]       paddr;
  logic [31:0]       pwdata, prdata, r;
  logic [3:0]        pstrb;
  logic [122:0]      pad_in, pad_out, pad_oe_n, pad_ibe, pad_ext;
  logic [3:1][122:0] alt_out, alt_oe;
  logic [31:0][3:0]  input_src_sel;
  logic [15:0]       external_irq_pin, irq_lvl;
  logic [1:0]        irq_vec;
  int                n_mismatch, checked;
  int unsigned       m_port, m_mask, m_dat;
  logic [13:0]       rsv_addr [4] = '{14'h0000, 14'h000c, 14'h0c10, 14'h1084};
  int                irq_pins [2] = '{3, 12};

  pgiu_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_ibe(pad_ibe), .alt_out(alt_out),
    .alt_oe(alt_oe), .input_src_sel(input_src_sel), .reduced_pins(reduced_pins),
    .external_irq_pin(external_irq_pin), .irq_vec(irq_vec), .irq(irq));

  pgiu_pad_model u_pads (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_ext(pad_ext),
    .irq_lvl(irq_lvl), .pad_in(pad_in), .external_irq_pin(external_irq_pin));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the wait on pready is bounded so a hang ends the run
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
      results();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [13:0] a);
    apb(1'b0, a, 32'h0, 4'hf);
  endtask : rd

  // Reads until the masked value matches; synchroniser latency is not fixed here
  task automatic poll(input logic [13:0] a, input logic [31:0] m, input logic [31:0] x);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while ((r & m) !== x && n < 30);
    chk(r & m, x);
    if ((r & m) !== x) begin
      results();
    end
  endtask : poll

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    {arst_n, psel, penable, pwrite, reduced_pins, paddr, pwdata, pstrb} = '0;
    {irq_lvl, n_mismatch, checked} = '0;
    ce = 1'b1;
    void'($urandom(43617));
    for (int i = 0; i < 123; i++) begin
      pad_ext[i] = 1'($urandom);
      for (int k = 1; k < 4; k++) begin
        alt_out[k][i] = 1'($urandom);
        alt_oe[k][i]  = 1'($urandom);
      end
    end
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    // Identity is read-only, request enable starts cleared
    wr(pgiu_pkg::OFS_ID_LO, 32'hffff_ffff);
    rd(pgiu_pkg::OFS_ID_LO);
    chk(r, pgiu_pkg::IDENT_LO_VAL);
    rd(pgiu_pkg::OFS_ID_HI);
    chk(r, pgiu_pkg::IDENT_HI_VAL);
    rd(pgiu_pkg::OFS_REQEN);
    chk(r, 32'h0);
    foreach (rsv_addr[i]) begin
      rd(rsv_addr[i]);
      chk(32'(e), 32'h1);
    end
    // Pad 0 output with readback, pad 1 input; byte lane 0 only
    wr(pgiu_pkg::OFS_PCR, 32'h0002_0003);
    apb(1'b1, pgiu_pkg::OFS_GPDO, 32'h0101_0101, 4'h1);
    chk(32'(pad_out[1:0]), 32'h1);
    chk(32'({pad_oe_n[1:0], pad_ibe[1:0]}), 32'hb);
    poll(pgiu_pkg::OFS_GPDI, 32'h0101, {23'h0, pad_ext[1], 8'h1});
    // Port 0 (pads 0 to 31) all GPIO, parallel writes and masked writes to both halves
    for (int w = 0; w < 16; w++) begin
      wr(pgiu_pkg::OFS_PCR + 14'(4 * w), 32'h0003_0003);
    end
    m_port = $urandom;
    wr(pgiu_pkg::OFS_PGPDO, m_port);
    chk(pad_out[31:0], m_port);
    poll(pgiu_pkg::OFS_PGPDI, 32'hffff_ffff, m_port);
    for (int n = 0; n < 2; n++) begin
      m_mask = $urandom & 32'hffff;
      m_dat  = $urandom & 32'hffff;
      wr(pgiu_pkg::OFS_MASKED_PORT_OUTPUT + 14'(4 * n), (m_mask << 16) | m_dat);
      m_port = (m_port & ~(m_mask << (16 * n))) | ((m_dat & m_mask) << (16 * n));
      chk(pad_out[31:0], m_port);
    end
    // Pad 2 through each alternate function
    for (int s = 1; s < 4; s++) begin
      wr(pgiu_pkg::OFS_PCR + 14'h4, 32'h0003_0001 | 32'(s << 2));
      chk(32'({pad_out[2], pad_oe_n[2]}), 32'({alt_out[s][2], ~alt_oe[s][2]}));
    end
    // Input source selects keep the low nibble of each byte lane
    m_dat = $urandom;
    wr(pgiu_pkg::OFS_PSMI, m_dat);
    chk(32'(input_src_sel[3:0]), {m_dat[27:24], m_dat[19:16], m_dat[11:8], m_dat[3:0]});
    rd(pgiu_pkg::OFS_PSMI);
    chk(r, m_dat & 32'h0f0f_0f0f);
    // Reduced-pin variant hides pad configs past 79
    reduced_pins <= 1'b1;
    rd(pgiu_pkg::OFS_PCR + 14'd160);
    chk(32'(e), 32'h1);
    reduced_pins <= 1'b0;
    rd(pgiu_pkg::OFS_PCR + 14'd160);
    chk(32'(e), 32'h0);
    // Rising edge sets the flag once, mask and write-one-clear
    foreach (irq_pins[i]) begin
      automatic int p = irq_pins[i];
      wr(pgiu_pkg::OFS_RISE, 32'h1 << p);
      wr(pgiu_pkg::OFS_REQEN, 32'h1 << p);
      irq_lvl[p] <= 1'b1;
      poll(pgiu_pkg::OFS_FLAG, 32'hffff, 32'h1 << p);
      chk(32'({irq_vec, irq}), (p < 8) ? 32'h3 : 32'h5);
      wr(pgiu_pkg::OFS_REQEN, 32'h0);
      chk(32'(irq), 32'h0);
      wr(pgiu_pkg::OFS_FLAG, 32'h0);
      rd(pgiu_pkg::OFS_FLAG);
      chk(r, 32'h1 << p);
      wr(pgiu_pkg::OFS_FLAG, 32'h1 << p);
      irq_lvl[p] <= 1'b0;
      repeat (4) begin
        rd(pgiu_pkg::OFS_FLAG);
        chk(r, 32'h0);
      end
    end
    // Filter on pin 5: a one-cycle glitch is dropped, a held level passes
    wr(pgiu_pkg::OFS_IFMC + 14'd20, 32'h2);
    wr(pgiu_pkg::OFS_FILT, 32'h20);
    wr(pgiu_pkg::OFS_FALL, 32'h20);
    wr(pgiu_pkg::OFS_RISE, 32'h20);
    irq_lvl[5] <= 1'b1;
    @(posedge clk_sys);
    irq_lvl[5] <= 1'b0;
    repeat (4) begin
      rd(pgiu_pkg::OFS_FLAG);
      chk(r, 32'h0);
    end
    // Clock enable low freezes the pin path, so a held level is seen only once it returns
    wr(pgiu_pkg::OFS_REQEN, 32'h20);
    ce <= 1'b0;
    irq_lvl[5] <= 1'b1;
    repeat (12) @(posedge clk_sys);
    chk(32'({irq_vec, irq}), 32'h0);
    ce <= 1'b1;
    poll(pgiu_pkg::OFS_FLAG, 32'hffff, 32'h20);
    chk(32'({irq_vec, irq}), 32'h3);
    results();
  end
endmodule : tb_top
